// ==== src/vd_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "vd_params.svh"
module vd_ctrl (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic IO_STROBE_I,
    input wire logic [11:0] INSTR_I,
    input wire logic [11:0] AC_I,
    input wire logic COMP_GT_I,
    input wire logic CURSOR_KEY_I,
    input wire logic CPU_START_I,
    input wire logic VECTOR_DONE_I,
    output logic SKIP_O,
    output logic IRQ_BUS_O,
    output logic [9:0] X_O,
    output logic [9:0] Y_O,
    output logic [9:0] DAC_O,
    output var vd_pkg::vd_param_t PARAM_O,
    output var vd_pkg::vd_src_t COMP_SEL_O,
    output logic VEC_START_O,
    output logic INTEG_RST_O,
    output logic BUSY_O,
    output logic INT_O,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    // bit 0 of a word is its msb, so numbering runs backwards
    function automatic vd_pkg::vd_op_t vd_decode(input logic [11:0] w);
        vd_pkg::vd_op_t r;
        r = vd_pkg::OP_NONE;
        if (w[11:9] == `VD_XFER_OPC) begin
            unique case (w[8:3])
                `VD_DEV_CUR: begin
                    if (w[2:0] == `VD_OP_1) r = vd_pkg::OP_SKIP_CUR;
                    if (w[2:0] == `VD_OP_2) r = vd_pkg::OP_CLR_CUR;
                end
                `VD_DEV_VEC: begin
                    if (w[2:0] == `VD_OP_1) r = vd_pkg::OP_LOAD_X;
                    if (w[2:0] == `VD_OP_2) r = vd_pkg::OP_SEL_CMP;
                    if (w[2:0] == `VD_OP_3) r = vd_pkg::OP_LOAD_PAR;
                    if (w[2:0] == `VD_OP_4) r = vd_pkg::OP_LOAD_Y;
                    if (w[2:0] == `VD_OP_5) r = vd_pkg::OP_EXEC;
                end
                `VD_DEV_RDY: begin
                    if (w[2:0] == `VD_OP_1) r = vd_pkg::OP_SKIP_RDY;
                    if (w[2:0] == `VD_OP_2) r = vd_pkg::OP_LOAD_DAC;
                    if (w[2:0] == `VD_OP_4) r = vd_pkg::OP_SKIP_CMP;
                    if (w[2:0] == `VD_OP_6) r = vd_pkg::OP_INT_RST;
                end
                default: r = vd_pkg::OP_NONE;
            endcase
        end
        return r;
    endfunction : vd_decode

    function automatic logic vd_mine(input logic [11:0] w);
        return w[11:9] == `VD_XFER_OPC &&
            (w[8:3] == `VD_DEV_CUR || w[8:3] == `VD_DEV_VEC ||
             w[8:3] == `VD_DEV_RDY);
    endfunction : vd_mine

    vd_pkg::vd_op_t op;
    vd_pkg::vd_state_t state_q;
    logic is_skip;
    logic accept;
    logic done_evt;
    logic ready_q;
    logic cursor_q;
    logic key_q;
    logic skip_q;
    logic [9:0] x_q;
    logic [9:0] y_q;
    logic [9:0] dac_q;
    logic [9:0] coord;
    logic [2:0] src_code;
    vd_pkg::vd_param_t param_q;
    vd_pkg::vd_src_t sel_q;
    logic vec_start_q;
    logic integ_rst_q;
    logic [`VD_EVT_W-1:0] evt;
    logic [`VD_EVT_W-1:0] status_q;
    logic [`VD_EVT_W-1:0] mask_q;
    logic apb_wr;
    logic mapped;

    // one action per strobe: the op field is decoded as a whole combination
    assign op = IO_STROBE_I ? vd_decode(INSTR_I) : vd_pkg::OP_NONE;
    assign is_skip = op == vd_pkg::OP_SKIP_CUR ||
        op == vd_pkg::OP_SKIP_RDY || op == vd_pkg::OP_SKIP_CMP;
    // skips are not commands: a ready poll must not drop ready itself
    assign accept = op != vd_pkg::OP_NONE && !is_skip &&
        state_q == vd_pkg::ST_IDLE;
    assign done_evt = state_q == vd_pkg::ST_FINISH ||
        (state_q == vd_pkg::ST_DRAW && VECTOR_DONE_I);
    assign coord = AC_I[9:0];
    assign src_code = {AC_I[9], AC_I[8], AC_I[5]};

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q <= vd_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                vd_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_q <= (op == vd_pkg::OP_EXEC) ?
                            vd_pkg::ST_DRAW : vd_pkg::ST_FINISH;
                    end
                end
                vd_pkg::ST_FINISH: state_q <= vd_pkg::ST_IDLE;
                vd_pkg::ST_DRAW: begin
                    if (VECTOR_DONE_I) state_q <= vd_pkg::ST_IDLE;
                end
                default: state_q <= vd_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ready_q <= 1'b0;
        end else if (CPU_START_I || accept) begin
            ready_q <= 1'b0;
        end else if (done_evt) begin
            ready_q <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            key_q <= 1'b0;
            cursor_q <= 1'b0;
        end else begin
            key_q <= CURSOR_KEY_I;
            // a press in the clearing cycle still wins
            if (CURSOR_KEY_I && !key_q) begin
                cursor_q <= 1'b1;
            end else if (CPU_START_I ||
                (accept && op == vd_pkg::OP_CLR_CUR)) begin
                cursor_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            skip_q <= 1'b0;
        end else begin
            skip_q <= (op == vd_pkg::OP_SKIP_CUR && cursor_q) ||
                (op == vd_pkg::OP_SKIP_RDY && ready_q) ||
                (op == vd_pkg::OP_SKIP_CMP && COMP_GT_I);
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            x_q <= 10'h000;
            y_q <= 10'h000;
        end else if (accept) begin
            // data state: the instruction picks the axis
            if (op == vd_pkg::OP_LOAD_X) begin
                x_q <= param_q.rel ? 10'(x_q + coord) : coord;
            end
            if (op == vd_pkg::OP_LOAD_Y) begin
                y_q <= param_q.rel ? 10'(y_q + coord) : coord;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            param_q <= '0;
        end else if (accept && op == vd_pkg::OP_LOAD_PAR) begin
            // parameter state: the word steers the next drawing
            param_q.rel <= AC_I[`VD_PAR_REL];
            param_q.kind <= AC_I[`VD_PAR_KIND_LSB +: 3];
            param_q.disp <= AC_I[`VD_PAR_DISP_LSB +: 2];
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sel_q <= vd_pkg::SRC_X_INT;
        end else if (accept && op == vd_pkg::OP_SEL_CMP) begin
            // codes 010 and 011 name no source and leave the choice alone
            unique case (src_code)
                3'h0: sel_q <= vd_pkg::SRC_X_INT;
                3'h1: sel_q <= vd_pkg::SRC_Y_INT;
                3'h4: sel_q <= vd_pkg::SRC_X_SH;
                3'h5: sel_q <= vd_pkg::SRC_Y_SH;
                3'h6: sel_q <= vd_pkg::SRC_X_CUR;
                3'h7: sel_q <= vd_pkg::SRC_Y_CUR;
                default: sel_q <= sel_q;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dac_q <= 10'h000;
            vec_start_q <= 1'b0;
            integ_rst_q <= 1'b0;
        end else begin
            if (accept && op == vd_pkg::OP_LOAD_DAC) dac_q <= coord;
            vec_start_q <= accept && op == vd_pkg::OP_EXEC;
            integ_rst_q <= accept && op == vd_pkg::OP_INT_RST;
        end
    end

    // events for the apb-side interrupt
    assign evt[`VD_EVT_READY] = done_evt;
    assign evt[`VD_EVT_KEY] = CURSOR_KEY_I && !key_q;
    assign evt[`VD_EVT_BADOP] = IO_STROBE_I && vd_mine(INSTR_I) &&
        op == vd_pkg::OP_NONE;

    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign mapped = PADDR == `VD_ADDR_STATUS ||
        PADDR == `VD_ADDR_MASK || PADDR == `VD_ADDR_FLAGS;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            status_q <= '0;
        end else if (apb_wr && PADDR == `VD_ADDR_STATUS) begin
            // set wins over a write-one-to-clear in the same cycle
            status_q <= (status_q & ~PWDATA[`VD_EVT_W-1:0]) | evt;
        end else begin
            status_q <= status_q | evt;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            mask_q <= '0;
        end else if (apb_wr && PADDR == `VD_ADDR_MASK) begin
            mask_q <= PWDATA[`VD_EVT_W-1:0];
        end
    end

    always_comb begin
        PRDATA = 32'h0000_0000;
        if (PSEL && !PWRITE) begin
            unique case (PADDR)
                `VD_ADDR_STATUS: PRDATA[`VD_EVT_W-1:0] = status_q;
                `VD_ADDR_MASK: PRDATA[`VD_EVT_W-1:0] = mask_q;
                `VD_ADDR_FLAGS: PRDATA[12:0] = {param_q, sel_q,
                    1'b0, state_q != vd_pkg::ST_IDLE, cursor_q, ready_q};
                default: PRDATA = 32'h0000_0000;
            endcase
        end
    end

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign INT_O = |(status_q & mask_q);
    assign IRQ_BUS_O = ready_q || cursor_q;
    assign SKIP_O = skip_q;
    assign X_O = x_q;
    assign Y_O = y_q;
    assign DAC_O = dac_q;
    assign PARAM_O = param_q;
    assign COMP_SEL_O = sel_q;
    assign VEC_START_O = vec_start_q;
    assign INTEG_RST_O = integ_rst_q;
    assign BUSY_O = state_q != vd_pkg::ST_IDLE;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    chk_opcode_gate: assert property (
        IO_STROBE_I && INSTR_I[11:9] != `VD_XFER_OPC |=>
            !skip_q && $stable(x_q) && $stable(y_q) && $stable(param_q))
        else $error("non-io word caused an action");
    chk_foreign_dev: assert property (
        IO_STROBE_I && !vd_mine(INSTR_I) && !CPU_START_I && !done_evt |=>
            !skip_q && $stable(ready_q) && $stable(dac_q))
        else $error("foreign device code was answered");
    chk_load_abs: assert property (
        accept && op == vd_pkg::OP_LOAD_X && !param_q.rel |=>
            x_q == $past(AC_I[9:0]))
        else $error("absolute x load wrong");
    chk_load_rel: assert property (
        accept && op == vd_pkg::OP_LOAD_Y && param_q.rel |=>
            y_q == 10'($past(y_q) + $past(AC_I[9:0])))
        else $error("relative y load wrong");
    chk_ready_cycle: assert property (
        accept && op != vd_pkg::OP_EXEC && !CPU_START_I |=>
            !ready_q ##1 (ready_q || $past(CPU_START_I)))
        else $error("ready did not drop and rise");
    chk_draw_wait: assert property (
        accept && op == vd_pkg::OP_EXEC |=>
            !ready_q && VEC_START_O && BUSY_O)
        else $error("vector start or ready wrong");
    chk_ready_skip: assert property (
        op == vd_pkg::OP_SKIP_RDY |=> skip_q == $past(ready_q))
        else $error("ready skip wrong");
    chk_key_sets: assert property (
        CURSOR_KEY_I && !key_q |=> cursor_q ##0 IRQ_BUS_O)
        else $error("key did not set cursor flag");
    chk_comp_skip: assert property (
        op == vd_pkg::OP_SKIP_CMP |=> skip_q == $past(COMP_GT_I))
        else $error("comparator skip wrong");
    chk_start_clear: assert property (
        CPU_START_I && !(CURSOR_KEY_I && !key_q) |=> !cursor_q && !ready_q)
        else $error("start did not clear flags");
    chk_unassigned: assert property (
        evt[`VD_EVT_BADOP] && !CPU_START_I && !done_evt |=>
            $stable(ready_q) && $stable(sel_q) && $stable(x_q) && !skip_q)
        else $error("unassigned op changed state");
endmodule : vd_ctrl
`default_nettype wire

// ==== shared/vd_params.svh ====
`ifndef VD_PARAMS_SVH
`define VD_PARAMS_SVH
`define VD_XFER_OPC 3'h6
`define VD_DEV_CUR 6'h05
`define VD_DEV_VEC 6'h06
`define VD_DEV_RDY 6'h07
`define VD_OP_1 3'h1
`define VD_OP_2 3'h2
`define VD_OP_3 3'h3
`define VD_OP_4 3'h4
`define VD_OP_5 3'h5
`define VD_OP_6 3'h6
`define VD_PAR_REL 0
`define VD_PAR_KIND_LSB 1
`define VD_PAR_DISP_LSB 4
`define VD_ADDR_STATUS 12'h000
`define VD_ADDR_MASK 12'h004
`define VD_ADDR_FLAGS 12'h008
`define VD_EVT_W 3
`define VD_EVT_READY 0
`define VD_EVT_KEY 1
`define VD_EVT_BADOP 2
`endif

// ==== shared/vd_pkg.sv ====
`default_nettype none
package vd_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_SKIP_CUR, OP_CLR_CUR, OP_LOAD_X, OP_SEL_CMP,
        OP_LOAD_Y, OP_LOAD_PAR, OP_EXEC, OP_SKIP_RDY, OP_LOAD_DAC,
        OP_SKIP_CMP, OP_INT_RST
    } vd_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_FINISH, ST_DRAW} vd_state_t;
    typedef enum logic [2:0] {
        SRC_X_INT, SRC_Y_INT, SRC_X_SH, SRC_Y_SH, SRC_X_CUR, SRC_Y_CUR
    } vd_src_t;
    typedef struct packed {
        logic [1:0] disp;
        logic [2:0] kind;
        logic rel;
    } vd_param_t;
endpackage : vd_pkg
`default_nettype wire

// ==== testbench/vd_proc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module vd_proc_model (
    input wire logic clk_i,
    input wire logic skip_i,
    output logic strobe_o,
    output logic [11:0] instr_o,
    output logic [11:0] ac_o
);
    initial begin
        strobe_o = 1'b0;
        instr_o = 12'h000;
        ac_o = 12'h000;
    end
    // one word per strobe, so only one pulse combination acts at a time
    task automatic xfer(input logic [11:0] ins, input logic [11:0] a,
                       output logic skip);
        @(posedge clk_i);
        strobe_o <= 1'b1;
        instr_o <= ins;
        ac_o <= a;
        @(posedge clk_i);
        strobe_o <= 1'b0;
        // released bus shows junk so a stale word never looks live
        instr_o <= ~ins;
        ac_o <= ~a;
        @(negedge clk_i);
        skip = skip_i;
    endtask : xfer
endmodule : vd_proc_model
`default_nettype wire

// ==== testbench/vector_display_io_command_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module vector_display_io_command_control_tb;
    logic clk = 1'b0, rst_n = 1'b0, comp_gt = 1'b0, key = 1'b0;
    logic start = 1'b0, vdone = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, skip, irq, vstart, irst, busy, intr, pready, perr;
    logic strb, sk, er;
    logic [11:0] paddr = 12'h000, instr, ac, r;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0] x, y, dac, v, ex, ey;
    logic [2:0] es;
    logic [5:0] ep;
    vd_pkg::vd_param_t par;
    vd_pkg::vd_src_t sel;
    integer seed = 55, mismatches = 0, checked = 0, i, k, m;
    always #4 clk = ~clk;
    vd_ctrl vd_ctrl_i (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .IO_STROBE_I(strb), .INSTR_I(instr), .AC_I(ac),
        .COMP_GT_I(comp_gt), .CURSOR_KEY_I(key), .CPU_START_I(start),
        .VECTOR_DONE_I(vdone), .SKIP_O(skip), .IRQ_BUS_O(irq), .X_O(x),
        .Y_O(y), .DAC_O(dac), .PARAM_O(par), .COMP_SEL_O(sel),
        .VEC_START_O(vstart), .INTEG_RST_O(irst), .BUSY_O(busy),
        .INT_O(intr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(perr));
    vd_proc_model vd_proc_model_i (.clk_i(clk), .skip_i(skip),
        .strobe_o(strb), .instr_o(instr), .ac_o(ac));
    task automatic close_out();
        if (mismatches == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                       input string msg);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic op(input logic [5:0] dev, input logic [2:0] o,
                      input logic [11:0] a);
        vd_proc_model_i.xfer({3'h6, dev, o}, a, sk);
    endtask : op
    task automatic idle();
        for (i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
        cmp(busy, 32'h0, "busy stuck");
    endtask : idle
    task automatic press();
        @(posedge clk);
        key <= 1'b1;
        repeat (3) @(posedge clk);
        key <= 1'b0;
    endtask : press
    function automatic logic [2:0] sel_of(input logic [11:0] a);
        logic [2:0] c;
        c = {a[9], a[8], a[5]};
        return c[2] ? c - 3'h2 : c;
    endfunction : sel_of
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        ex = 10'h000;
        ey = 10'h000;
        es = 3'h0;
        apb(1'b0, 12'h008, 32'h0);
        cmp(rd, 32'h0, "flags reset");
        cmp(pready, 32'h1, "pready");
        apb(1'b1, 12'h004, 32'h7);
        apb(1'b0, 12'h004, 32'h0);
        cmp(rd, 32'h7, "mask");
        for (m = 0; m < 2; m++) begin
            r = 12'($random(seed));
            r[0] = (m == 0);
            op(6'h06, 3'h3, r);
            ep = {r[5:4], r[3:1], r[0]};
            cmp(par, ep, "param");
            idle();
            for (k = 0; k < 6; k++) begin
                r = 12'($random(seed));
                v = r[9:0];
                op(6'h06, k[0] ? 3'h4 : 3'h1, r);
                if (k[0])
                    ey = (m == 0) ? ey + v : v;
                else
                    ex = (m == 0) ? ex + v : v;
                cmp({x, y}, {ex, ey}, "coord");
                cmp(irq, 32'h0, "ready kept");
                idle();
                cmp(irq, 32'h1, "no ready irq");
                op(6'h07, 3'h1, 12'h000);
                cmp(sk, 32'h1, "ready skip");
            end
        end
        apb(1'b1, 12'h000, 32'h7);
        op(6'h04, 3'h1, 12'h155);
        vd_proc_model_i.xfer({3'h4, 6'h06, 3'h1}, 12'h2AA, sk);
        cmp({x, irq}, {ex, 1'b1}, "foreign word");
        op(6'h05, 3'h3, 12'h0F0);
        cmp({x, irq}, {ex, 1'b1}, "unassigned op");
        apb(1'b0, 12'h000, 32'h0);
        cmp(rd, 32'h4, "bad op event");
        cmp(intr, 32'h1, "bad op int");
        apb(1'b1, 12'h000, 32'h4);
        apb(1'b1, 12'h004, 32'h0);
        op(6'h07, 3'h7, 12'h000);
        cmp(intr, 32'h0, "masked int");
        apb(1'b1, 12'h000, 32'h4);
        apb(1'b0, 12'h010, 32'h0);
        cmp(rd, 32'h0, "unmapped read");
        cmp(er, 32'h1, "unmapped error");
        press();
        op(6'h05, 3'h1, 12'h000);
        cmp({sk, irq}, 32'h3, "cursor set");
        op(6'h05, 3'h2, 12'h000);
        op(6'h05, 3'h1, 12'h000);
        cmp(sk, 32'h0, "cursor clear");
        press();
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        op(6'h05, 3'h1, 12'h000);
        cmp({sk, irq}, 32'h0, "start clear");
        for (k = 0; k < 8; k++) begin
            r = 12'($random(seed));
            {r[9], r[8], r[5]} = k[2:0];
            op(6'h06, 3'h2, r);
            if (k[2:1] != 2'h1)
                es = sel_of(r);
            cmp(sel, es, "comp select");
            idle();
        end
        apb(1'b0, 12'h008, 32'h0);
        cmp(rd, {19'h0, ep, es, 4'h1}, "flags layout");
        for (k = 0; k < 2; k++) begin
            @(posedge clk);
            comp_gt <= k[0];
            op(6'h07, 3'h4, 12'h000);
            cmp(sk, k[0], "comp skip");
        end
        r = 12'($random(seed));
        op(6'h07, 3'h2, r);
        cmp(dac, r[9:0], "dac");
        idle();
        op(6'h07, 3'h6, 12'h000);
        cmp(irst, 32'h1, "integ reset");
        idle();
        op(6'h06, 3'h5, 12'h000);
        cmp({vstart, busy}, 32'h3, "exec");
        op(6'h06, 3'h1, 12'h3FF);
        op(6'h07, 3'h1, 12'h000);
        cmp({sk, x}, {1'b0, ex}, "busy refusal");
        @(posedge clk);
        vdone <= 1'b1;
        @(posedge clk);
        vdone <= 1'b0;
        idle();
        op(6'h07, 3'h1, 12'h000);
        cmp(sk, 32'h1, "done ready");
        close_out();
    end
endmodule : vector_display_io_command_control_tb
`default_nettype wire
